// *** rokp_defines.svh ***
// register offsets, field positions, key values and reset values of the oscillator/power bank
// assumes an 8-bit register port with a one-cycle write strobe from the serial front end
`ifndef ROKP_DEFINES_SVH
`define ROKP_DEFINES_SVH
`define ROKP_OFS_OSC_CTRL   8'h1c
`define ROKP_OFS_OSC_STAT   8'h1d
`define ROKP_OFS_KEY        8'h1f
`define ROKP_OFS_TRICKLE    8'h20
`define ROKP_OFS_BATTERY_THRESHOLD_SEL       8'h21
`define ROKP_OFS_VREF       8'h22
`define ROKP_OFS_BATIO      8'h27
`define ROKP_OFS_ANALOG     8'h2f
`define ROKP_OFS_OUTCTL     8'h30
`define ROKP_KEY_OSC        8'ha1
`define ROKP_KEY_SWRST      8'h3c
`define ROKP_KEY_ANALOG     8'h9d
`define ROKP_KEY_CLEAR      8'h00
`define ROKP_RST_OSC_CTRL   8'h00
`define ROKP_RST_OSC_STAT   8'h00
`define ROKP_RST_TRICKLE    8'h00
`define ROKP_RST_BATTERY_THRESHOLD_SEL       8'h00
`define ROKP_RST_BATIO      8'h80
`define ROKP_RST_OUTCTL     8'h00
`define ROKP_TCS_ON         4'ha
`define ROKP_DIODE_IN       2'h2
`define ROKP_DIODE_OUT      2'h1
`define ROKP_TRICKLE_RESISTOR_SEL_OFF       2'h0
`define ROKP_ACAL_OFF       2'h0
`define ROKP_VREF_TRIM_MSB  4
`define ROKP_BATIO_KEEP     7
`define ROKP_STAT_WMASK     8'he3
`endif

// *** rokp_pkg.sv ***
// types shared by the oscillator/power register bank
// assumes rokp_defines.svh is on the include path
package rokp_pkg;
  typedef struct packed {
    logic       oscillator_select;
    logic [1:0] acal_mode;
    logic       battery_rc_switch;
    logic       failure_rc_switch;
    logic       io_gate_on_power_switch;
    logic       osc_fail_irq_en;
    logic       autocal_fail_irq_en;
  } rokp_osc_ctrl_s;
  typedef struct packed {
    logic [1:0] crystal_slowdown;
    logic       output2_lock;
    logic       active_osc_indicator;
    logic       crystal_not_running;
    logic       unused_2;
    logic       osc_fail_flag;
    logic       autocal_fail_flag;
  } rokp_osc_stat_s;
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rokp_wr_s;
  typedef struct packed {
    logic battery_above_threshold;
    logic battery_min_ok;
    logic supply_init_ok;
    logic on_battery;
    logic crystal_running;
    logic crystal_slow;
    logic autocal_fail;
  } rokp_analog_s;
  typedef enum logic [1:0] {ROKP_XT, ROKP_RC} rokp_osc_e;
endpackage

// *** rokp_edge_event.sv ***
// edge detector turning a comparator level into falling/rising one-cycle events
// assumes the level input is synchronous to ref_clk
`timescale 1ns/1ns
module rokp_edge_event (
  input  wire logic ref_clk,   // system clock
  input  wire logic reset_n,   // synchronous reset, active low
  input  wire logic level_in,  // comparator level
  output logic      fall_ev,   // one-cycle fall pulse
  output logic      rise_ev    // one-cycle rise pulse
);
  logic last_ff;
  // remember previous level, start high so no false rise
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      last_ff <= 1'b1;
      fall_ev <= 1'b0;
      rise_ev <= 1'b0;
    end else begin
      last_ff <= level_in;
      fall_ev <= last_ff & ~level_in;
      rise_ev <= ~last_ff & level_in;
    end
  end
endmodule

// *** rokp_regs.sv ***
// key-protected oscillator, trickle, reference and battery-mode register bank
// assumes an 8-bit register port; analog and oscillator status come from the analog core
`timescale 1ns/1ns
`include "rokp_defines.svh"
// How it works
// - oscillator control writable only while key holds the oscillator key
// - nonzero autocal mode on a control write starts autocalibration at once
// - select bit requests RC or crystal; no crystal switch while crystal dead
// - battery auto-switch bit moves timebase to RC on battery power
// - failure auto-switch bit moves timebase to RC on crystal failure
// - io gate bit disables host io when switch mode and output2 are 1
// - failure flags raise interrupt when their enables are set
// - crystal slowdown field drives crystal trim, 122 ppm per unit
// - output2 lock refuses setting output2 level to one
// - active oscillator bit reads one when RC drives clocks
// - crystal not running bit reads one whenever crystal is not switching
// - oscillator failure flag set on power-on reset and slow crystal
// - autocal failure flag set on RC out of range or crystal dead during autocal
// - key register returns to zero after any write to another register
// - writing software-reset key pulses reset and leaves key unchanged
// - analog key unlocks trickle, reference and output control writes
// - trickle active only for enable code 1010, valid diode, nonzero resistor
// - threshold select picks level; falls set battery flag and events
// - analog status reports threshold, battery minimum and supply ok
// - reference trim low bits load inverse of nonvolatile trim at reset
// - battery io register resets 0x80, keyed, top bit keeps io on battery
// - output control bits 7 and 6 enable watchdog and external inputs
module rokp_regs
  import rokp_pkg::*;
#(
  parameter int TRIM_W = 5  // width of nonvolatile trim source
) (
  input  wire logic                ref_clk,                 // 20 MHz system clock
  input  wire logic                reset_n,                 // synchronous reset, active low
  input  wire rokp_pkg::rokp_wr_s  wr,                      // write strobe, address, data
  input  wire logic [7:0]          rd_addr,                 // read address
  input  wire rokp_pkg::rokp_analog_s ana,                  // analog core status
  input  wire logic [TRIM_W-1:0]   nonvolatile_trim_source, // trim value from nvm
  input  wire logic                switch_mode_bit,         // power switch mode
  input  wire logic                output2_level,           // requested output2 level
  input  wire logic                watchdog_input_pin,      // watchdog input pin
  input  wire logic                external_int_pin,        // external interrupt pin
  output logic [7:0]               rd_data,                 // read data
  output logic                     output2_pin,             // output2 level after lock
  output logic                     rc_active,               // timebase runs from RC
  output logic                     autocal_start,           // one-cycle autocal start
  output logic                     sw_reset,                // one-cycle software reset
  output logic                     irq,                     // failure interrupt
  output logic                     io_enable,               // host io enabled
  output logic                     trickle_on,              // trickle charger active
  output logic [3:0]               battery_threshold_sel,   // comparator level select
  output logic [1:0]               crystal_slowdown,        // crystal slowdown steps
  output logic [7:0]               vref_trim,               // reference trim value
  output logic                     battery_flag,            // sticky battery flag
  output logic                     battery_low_fall,        // falling battery event
  output logic                     battery_low_rise,        // rising battery event
  output logic                     wdog_in,                 // gated watchdog input
  output logic                     ext_in                   // gated external input
);
  import rokp_pkg::*;

  rokp_osc_ctrl_s ctrl_ff;
  rokp_osc_stat_s stat_ff;
  logic [7:0] key_ff, trickle_ff, battery_threshold_sel_ff, batio_ff, outctl_ff, vref_ff;
  logic       acal_busy_ff, init_ff, fall_ev, rise_ev;
  logic       wr_osc, wr_key, wr_ana, key_osc_ok, key_ana_ok, rc_want;

  // write decode helper used for every register
  function automatic logic hit(input rokp_wr_s w, input logic [7:0] ofs);
    return w.we && (w.addr == ofs);
  endfunction

  // keyed write qualifiers
  assign key_osc_ok = (key_ff == `ROKP_KEY_OSC);
  assign key_ana_ok = (key_ff == `ROKP_KEY_ANALOG);
  assign wr_osc = hit(wr, `ROKP_OFS_OSC_CTRL) && key_osc_ok;
  assign wr_key = hit(wr, `ROKP_OFS_KEY);
  assign wr_ana = key_ana_ok;

  // configuration key: reset by any write to another register, swrst key leaves it alone
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      key_ff   <= `ROKP_KEY_CLEAR;
      sw_reset <= 1'b0;
    end else begin
      sw_reset <= wr_key && (wr.wdata == `ROKP_KEY_SWRST);
      if (wr_key) begin
        if (wr.wdata != `ROKP_KEY_SWRST)
          key_ff <= wr.wdata;
      end else if (wr.we) begin
        key_ff <= `ROKP_KEY_CLEAR;
      end
    end
  end

  // oscillator control and autocal start
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_ff       <= `ROKP_RST_OSC_CTRL;
      autocal_start <= 1'b0;
    end else begin
      autocal_start <= wr_osc && (wr.wdata[6:5] != `ROKP_ACAL_OFF);
      if (wr_osc)
        ctrl_ff <= wr.wdata;
    end
  end

  // oscillator status: writable fields plus sticky failure flags
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stat_ff <= `ROKP_RST_OSC_STAT;
      init_ff <= 1'b1;
    end else begin
      init_ff <= 1'b0;
      if (hit(wr, `ROKP_OFS_OSC_STAT)) begin
        stat_ff.crystal_slowdown  <= wr.wdata[7:6];
        stat_ff.output2_lock      <= wr.wdata[5];
        stat_ff.osc_fail_flag     <= wr.wdata[1];
        stat_ff.autocal_fail_flag <= wr.wdata[0];
      end
      // hardware set wins over a software clear
      if (init_ff || ana.crystal_slow)
        stat_ff.osc_fail_flag <= 1'b1;
      if (ana.autocal_fail || (acal_busy_ff && !ana.crystal_running))
        stat_ff.autocal_fail_flag <= 1'b1;
      stat_ff.active_osc_indicator <= rc_want;
      stat_ff.crystal_not_running  <= ~ana.crystal_running;
      stat_ff.unused_2             <= 1'b0;
    end
  end

  // autocal cycle tracker so a dead crystal during it flags failure
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      acal_busy_ff <= 1'b0;
    else
      acal_busy_ff <= (ctrl_ff.acal_mode != `ROKP_ACAL_OFF);
  end

  // timebase selection
  always_comb begin
    rc_want = ctrl_ff.oscillator_select;
    if (ctrl_ff.battery_rc_switch && ana.on_battery) rc_want = 1'b1;
    if (ctrl_ff.failure_rc_switch && stat_ff.osc_fail_flag) rc_want = 1'b1;
    if (!ana.crystal_running) rc_want = 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rc_active <= 1'b0;
      irq       <= 1'b0;
    end else begin
      rc_active <= rc_want;
      irq <= (ctrl_ff.osc_fail_irq_en && stat_ff.osc_fail_flag) ||
             (ctrl_ff.autocal_fail_irq_en && stat_ff.autocal_fail_flag);
    end
  end

  // analog-key protected registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      trickle_ff <= `ROKP_RST_TRICKLE;
      battery_threshold_sel_ff    <= `ROKP_RST_BATTERY_THRESHOLD_SEL;
      batio_ff   <= `ROKP_RST_BATIO;
      outctl_ff  <= `ROKP_RST_OUTCTL;
    end else begin
      if (wr_ana && hit(wr, `ROKP_OFS_TRICKLE)) trickle_ff <= wr.wdata;
      if (wr_ana && hit(wr, `ROKP_OFS_BATTERY_THRESHOLD_SEL))    battery_threshold_sel_ff    <= wr.wdata;
      if (wr_ana && hit(wr, `ROKP_OFS_BATIO))   batio_ff   <= wr.wdata;
      if (wr_ana && hit(wr, `ROKP_OFS_OUTCTL))  outctl_ff  <= wr.wdata;
    end
  end

  // reference trim: low bits loaded with inverted nvm trim on the first cycle after reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      vref_ff <= 8'h00;
    else if (init_ff)
      vref_ff[`ROKP_VREF_TRIM_MSB:0] <= ~nonvolatile_trim_source;
    else if (wr_ana && hit(wr, `ROKP_OFS_VREF))
      vref_ff <= wr.wdata;
  end

  // battery comparator edges
  rokp_edge_event u_bat_edge (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .level_in (ana.battery_above_threshold),
    .fall_ev  (fall_ev),
    .rise_ev  (rise_ev)
  );

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      battery_flag     <= 1'b0;
      battery_low_fall <= 1'b0;
      battery_low_rise <= 1'b0;
    end else begin
      battery_low_fall <= fall_ev;
      battery_low_rise <= rise_ev;
      if (fall_ev) battery_flag <= 1'b1;
    end
  end

  // derived outputs, all registered
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      output2_pin           <= 1'b0;
      io_enable             <= 1'b1;
      trickle_on            <= 1'b0;
      battery_threshold_sel <= 4'h0;
      crystal_slowdown      <= 2'h0;
      vref_trim             <= 8'h00;
      wdog_in               <= 1'b1;
      ext_in                <= 1'b1;
    end else begin
      output2_pin <= output2_level && !stat_ff.output2_lock;
      io_enable <= !(ctrl_ff.io_gate_on_power_switch && switch_mode_bit && output2_pin)
                   && (!ana.on_battery || batio_ff[`ROKP_BATIO_KEEP]);
      trickle_on <= (trickle_ff[7:4] == `ROKP_TCS_ON) &&
                    (trickle_ff[3:2] == `ROKP_DIODE_IN || trickle_ff[3:2] == `ROKP_DIODE_OUT) &&
                    (trickle_ff[1:0] != `ROKP_TRICKLE_RESISTOR_SEL_OFF);
      battery_threshold_sel <= battery_threshold_sel_ff[7:4];
      crystal_slowdown      <= stat_ff.crystal_slowdown;
      vref_trim             <= vref_ff;
      wdog_in <= (ana.on_battery && !outctl_ff[7]) ? 1'b1 : watchdog_input_pin;
      ext_in  <= (ana.on_battery && !outctl_ff[6]) ? 1'b1 : external_int_pin;
    end
  end

  // read mux
  always_ff @(posedge ref_clk) begin
    if (!reset_n)
      rd_data <= 8'h00;
    else
      unique case (rd_addr)
        `ROKP_OFS_OSC_CTRL: rd_data <= ctrl_ff;
        `ROKP_OFS_OSC_STAT: rd_data <= stat_ff;
        `ROKP_OFS_KEY:      rd_data <= key_ff;
        `ROKP_OFS_TRICKLE:  rd_data <= trickle_ff;
        `ROKP_OFS_BATTERY_THRESHOLD_SEL:     rd_data <= battery_threshold_sel_ff;
        `ROKP_OFS_VREF:     rd_data <= vref_ff;
        `ROKP_OFS_BATIO:    rd_data <= batio_ff;
        `ROKP_OFS_ANALOG:   rd_data <= {ana.battery_above_threshold, ana.battery_min_ok,
                                        4'h0, ana.supply_init_ok, 1'b0};
        `ROKP_OFS_OUTCTL:   rd_data <= outctl_ff;
        default:            rd_data <= 8'h00;
      endcase
  end

  // checks
  key_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr.we && !wr_key |=> key_ff == `ROKP_KEY_CLEAR) else $error("key not cleared");
  swrst_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_key && wr.wdata == `ROKP_KEY_SWRST |=> sw_reset && $stable(key_ff))
    else $error("swrst");
  osc_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hit(wr, `ROKP_OFS_OSC_CTRL) && !key_osc_ok |=> $stable(ctrl_ff)) else $error("osc lock");
  acal_go_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_osc && wr.wdata[6:5] != `ROKP_ACAL_OFF |=> autocal_start) else $error("acal");
  output2_pin_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    stat_ff.output2_lock |=> !output2_pin) else $error("output2_pin lock");
  ana_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hit(wr, `ROKP_OFS_TRICKLE) && !key_ana_ok |=> $stable(trickle_ff)) else $error("trickle");
  bat_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fall_ev |=> battery_flag) else $error("bat flag");
  irq_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl_ff.osc_fail_irq_en && stat_ff.osc_fail_flag |=> irq) else $error("irq");
  crystal_rc_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ana.crystal_running |=> rc_active) else $error("rc");
  osc_fail_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    init_ff || ana.crystal_slow |=> stat_ff.osc_fail_flag) else $error("osc fail flag");
  cov_osc_c: cover property (@(posedge ref_clk) wr_osc);
  cov_swrst_c: cover property (@(posedge ref_clk) sw_reset);
  cov_trickle_c: cover property (@(posedge ref_clk) trickle_on);
  cov_fall_c: cover property (@(posedge ref_clk) battery_low_fall);
endmodule

// *** rokp_host_model.sv ***
// host processor model that issues register writes and reads to the bank
// assumes read data is registered one cycle after the read address
`timescale 1ns/1ns
module rokp_host_model
  import rokp_pkg::*;
(
  input  wire logic          ref_clk,  // system clock
  output rokp_pkg::rokp_wr_s wr,       // write request
  output logic [7:0]         rd_addr,  // read address
  input  wire logic [7:0]    rd_data   // read data
);
  // idle bus at time zero
  initial begin
    wr = '0;
    rd_addr = 8'h00;
  end
  // one write held for one edge, then address and data go to junk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= '{1'b1, a, d};
    @(posedge ref_clk);
    wr <= '{1'b0, ~a, ~d};
  endtask
  // key first, then exactly one protected write
  task automatic key_wr(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
    wr_reg(8'h1f, k);
    wr_reg(a, d);
  endtask
  // address on one edge, data taken after the next
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd_addr <= a;
    @(posedge ref_clk);
    #1 d = rd_data;
  endtask
endmodule

// *** rtc_osc_key_power_regs_tb.sv ***
// self-checking bench for the key-protected oscillator and power register bank
// assumes rokp_host_model drives the register port
`timescale 1ns/1ns
module rtc_osc_key_power_regs_tb;
  import rokp_pkg::*;
  typedef struct packed {
    logic [7:0] key;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
    logic       tr;
  } rokp_row_s;
  logic         ref_clk, reset_n, sw_mode, o2_lvl, wdi_pin, external_int_pin_pin;
  rokp_wr_s     wr;
  rokp_analog_s ana;
  logic [7:0]   rd_addr, rd_data, vtrim, r;
  logic [4:0]   nvm_trim;
  logic [3:0]   bsel;
  logic [1:0]   xslow;
  logic         o2_pin, rc_act, acal_st, swr, irq, io_en, tr_on;
  logic         bflag, bfall, brise, wd_in, ex_in;
  int           error_cnt = 0, checks_done = 0, n0, n1;
  int           n_acal = 0, n_swr = 0, n_fall = 0, n_rise = 0;
  rokp_row_s    rows [14] = '{
    '{8'h00, 8'h1c, 8'hff, 8'h00, 1'b0}, '{8'ha1, 8'h1c, 8'h1f, 8'h1f, 1'b0},
    '{8'h9d, 8'h1c, 8'h00, 8'h1f, 1'b0}, '{8'h9d, 8'h20, 8'ha9, 8'ha9, 1'b1},
    '{8'ha1, 8'h20, 8'h00, 8'ha9, 1'b1}, '{8'h9d, 8'h20, 8'ha5, 8'ha5, 1'b1},
    '{8'h9d, 8'h20, 8'had, 8'had, 1'b0}, '{8'h9d, 8'h20, 8'ha8, 8'ha8, 1'b0},
    '{8'h9d, 8'h20, 8'hb9, 8'hb9, 1'b0}, '{8'h9d, 8'h20, 8'haa, 8'haa, 1'b1},
    '{8'h9d, 8'h21, 8'h50, 8'h50, 1'b1}, '{8'h9d, 8'h27, 8'h00, 8'h00, 1'b1},
    '{8'h9d, 8'h30, 8'hc0, 8'hc0, 1'b1}, '{8'h9d, 8'h22, 8'h3f, 8'h3f, 1'b1}};
  logic [7:0]   rst_a [7] = '{8'h1c, 8'h1d, 8'h1f, 8'h20, 8'h21, 8'h27, 8'h30};
  logic [7:0]   rst_v [7] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  logic [7:0]   acal_v [4] = '{8'h20, 8'h40, 8'h60, 8'h00};

  // design and host
  rokp_regs dut (.ref_clk(ref_clk), .reset_n(reset_n), .wr(wr), .rd_addr(rd_addr), .ana(ana),
    .nonvolatile_trim_source(nvm_trim), .switch_mode_bit(sw_mode), .output2_level(o2_lvl),
    .watchdog_input_pin(wdi_pin), .external_int_pin(external_int_pin_pin), .rd_data(rd_data),
    .output2_pin(o2_pin), .rc_active(rc_act), .autocal_start(acal_st), .sw_reset(swr),
    .irq(irq), .io_enable(io_en), .trickle_on(tr_on), .battery_threshold_sel(bsel),
    .crystal_slowdown(xslow), .vref_trim(vtrim), .battery_flag(bflag),
    .battery_low_fall(bfall), .battery_low_rise(brise), .wdog_in(wd_in), .ext_in(ex_in));
  rokp_host_model host (.ref_clk(ref_clk), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data));

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // count one-cycle event pulses
  always @(posedge ref_clk) begin
    n_acal <= n_acal + int'(acal_st === 1'b1);
    n_swr <= n_swr + int'(swr === 1'b1);
    n_fall <= n_fall + int'(bfall === 1'b1);
    n_rise <= n_rise + int'(brise === 1'b1);
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(3);
  endtask
  // analog levels change on an edge, events need two cycles
  task automatic set_ana(input rokp_analog_s v);
    @(posedge ref_clk);
    ana <= v;
    idle(4);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #(20000 * 50);
    error_cnt++;
    end_of_test();
  end
  // main sequence
  initial begin
    reset_n = 1'b0;
    ana = 7'h74;
    nvm_trim = 5'h0b;
    {sw_mode, o2_lvl, wdi_pin, external_int_pin_pin} = 4'h0;
    do_reset();
    foreach (rows[i]) begin
      host.key_wr(rows[i].key, rows[i].addr, rows[i].data);
      host.rd_reg(rows[i].addr, r);
      chk("row read", r, rows[i].exp);
      chk("trickle", tr_on, rows[i].tr);
    end
    chk("threshold", bsel, 8'h05);
    // second reset: reset values, power-on flag, inverted trim
    do_reset();
    chk("trim", vtrim[4:0], 8'h14);
    foreach (rst_a[i]) begin
      host.rd_reg(rst_a[i], r);
      chk("reset value", r, rst_v[i]);
    end
    // key grants one write only
    host.wr_reg(8'h1f, 8'ha1);
    host.rd_reg(8'h1f, r);
    chk("key held", r, 8'ha1);
    host.wr_reg(8'h27, 8'h00);
    host.rd_reg(8'h1f, r);
    chk("key cleared", r, 8'h00);
    host.wr_reg(8'h1c, 8'hff);
    host.rd_reg(8'h1c, r);
    chk("ctrl locked", r, 8'h00);
    host.rd_reg(8'h27, r);
    chk("batio locked", r, 8'h80);
    // software reset key
    host.key_wr(8'h9d, 8'h1f, 8'h3c);
    idle(2);
    chk("sw reset", 8'(n_swr), 8'h01);
    host.rd_reg(8'h1f, r);
    chk("key kept", r, 8'h9d);
    // autocal start for each mode
    foreach (acal_v[i]) begin
      n0 = n_acal;
      host.key_wr(8'ha1, 8'h1c, acal_v[i]);
      idle(2);
      chk("autocal", 8'(n_acal - n0), 8'(acal_v[i][6:5] != 2'h0));
    end
    // interrupt enables against the two flags
    host.key_wr(8'ha1, 8'h1c, 8'h02);
    idle(2);
    chk("irq osc", irq, 1'b1);
    host.wr_reg(8'h1d, 8'h00);
    idle(2);
    chk("irq clear", irq, 1'b0);
    set_ana(7'h75);
    chk("irq masked", irq, 1'b0);
    host.key_wr(8'ha1, 8'h1c, 8'h01);
    idle(2);
    chk("irq acal", irq, 1'b1);
    set_ana(7'h74);
    host.wr_reg(8'h1d, 8'h00);
    // oscillator selection and automatic switching
    host.key_wr(8'ha1, 8'h1c, 8'h80);
    host.rd_reg(8'h1d, r);
    chk("rc chosen", {rc_act, r[4]}, 2'b11);
    host.key_wr(8'ha1, 8'h1c, 8'h00);
    host.rd_reg(8'h1d, r);
    chk("xt chosen", {rc_act, r[4]}, 2'b00);
    set_ana(7'h70);
    host.rd_reg(8'h1d, r);
    chk("xt dead", {rc_act, r[4:3]}, 3'b111);
    set_ana(7'h7c);
    chk("no auto", rc_act, 1'b0);
    chk("battery io", {io_en, wd_in, ex_in}, 3'b111);
    host.key_wr(8'h9d, 8'h30, 8'hc0);
    idle(2);
    chk("inputs on", {wd_in, ex_in}, 2'b00);
    host.key_wr(8'h9d, 8'h27, 8'h00);
    idle(2);
    chk("io off", io_en, 1'b0);
    host.key_wr(8'ha1, 8'h1c, 8'h10);
    idle(2);
    chk("battery rc", rc_act, 1'b1);
    set_ana(7'h76);
    chk("no fail rc", rc_act, 1'b0);
    host.key_wr(8'ha1, 8'h1c, 8'h08);
    host.rd_reg(8'h1d, r);
    chk("fail rc", {rc_act, r[1]}, 2'b11);
    set_ana(7'h74);
    // output2 lock, io gating and slowdown
    @(posedge ref_clk);
    o2_lvl <= 1'b1;
    sw_mode <= 1'b1;
    host.key_wr(8'ha1, 8'h1c, 8'h04);
    idle(2);
    chk("io gated", {o2_pin, io_en}, 2'b10);
    host.wr_reg(8'h1d, 8'h20);
    idle(2);
    chk("o2 locked", {o2_pin, io_en}, 2'b01);
    host.wr_reg(8'h1d, 8'hc0);
    idle(2);
    chk("slowdown", {xslow, o2_pin}, 3'b111);
    // analog status and battery events
    set_ana(7'h54);
    host.rd_reg(8'h2f, r);
    chk("analog a", r & 8'hc2, 8'h82);
    n0 = n_fall;
    n1 = n_rise;
    set_ana(7'h24);
    host.rd_reg(8'h2f, r);
    chk("analog b", r & 8'hc2, 8'h40);
    set_ana(7'h74);
    chk("bat events", {bflag, 2'(n_fall - n0), 2'(n_rise - n1)}, 8'h15);
    end_of_test();
  end
endmodule
